// ---- rtl/mcsm_defines.vh ----
// Constants of the cyclic shared-memory exchange block.
// Assumes a 250 MHz clock and a 32-bit AHB-Lite register bus.
`ifndef MCSM_DEFINES_VH
`define MCSM_DEFINES_VH
// Timing.
`define MCSM_CLK_NS        4
`define MCSM_CYCLE_NS      880000
`define MCSM_CYCLE_CLKS    (`MCSM_CYCLE_NS / `MCSM_CLK_NS)
`define MCSM_CHK_WAIT      3'h4
// Area-device addressing.
`define MCSM_AREA_LO       16'h2710
`define MCSM_AREA_HI       16'h5F0F
`define MCSM_SHARED_TOP    16'h0FFF
`define MCSM_KWORD_SHIFT   10
`define MCSM_MEM_WORDS     14336
`define MCSM_LIMIT_2CPU    6'h0E
`define MCSM_LIMIT_3CPU    6'h0D
`define MCSM_LIMIT_4CPU    6'h0C
`define MCSM_ERR_CODE      16'h1B63
// Access modes.
`define MCSM_MODE_WORD     2'h0
`define MCSM_MODE_BIT      2'h1
`define MCSM_MODE_DWORD    2'h2
// Register byte offsets.
`define MCSM_OFF_CTRL      8'h00
`define MCSM_OFF_SIZE      8'h04
`define MCSM_OFF_REF0      8'h08
`define MCSM_OFF_REF1      8'h0C
`define MCSM_OFF_REF2      8'h10
`define MCSM_OFF_REF3      8'h14
`define MCSM_OFF_REFBASE   8'h18
`define MCSM_OFF_ACCADDR   8'h1C
`define MCSM_OFF_ACCDATA   8'h20
`define MCSM_OFF_STATUS    8'h24
`define MCSM_OFF_MASK      8'h28
`define MCSM_OFF_INFO      8'h2C
// Reset values.
`define MCSM_CTRL_RST      4'h0
`define MCSM_SIZE_RST      16'h3333
`define MCSM_REF_RST       15'h0000
`define MCSM_IRQ_RST       6'h00
// Status bit positions.
`define MCSM_ST_TXDONE     0
`define MCSM_ST_RXDONE     1
`define MCSM_ST_ACCERR     2
`define MCSM_ST_SIZEERR    3
`define MCSM_ST_REFDONE    4
`define MCSM_ST_CFGERR     5
// Refresh engine states.
`define MCSM_RF_IDLE       5'h01
`define MCSM_RF_RD         5'h02
`define MCSM_RF_WAIT       5'h04
`define MCSM_RF_CAP        5'h08
`define MCSM_RF_PUT        5'h10
`endif

// ---- rtl/mcsm_shared_mem.v ----
// Cyclic shared-memory exchange between up to four processor modules.
// Assumes a same-clock link engine for tx/rx words and a device memory
// with one cycle read latency; sync and strap pins are asynchronous.
// What this block does
// - Send own area to peers every 0.88 ms.
// - Transfer runs beside program execution.
// - Cycle start follows motion operation cycle.
// - Total send size limited 14k/13k/12k.
// - Send areas 0..14k in 1k steps.
// - Own area sent, peer copies hold received.
// - User area even-sized, directly addressable.
// - Refresh area even-sized, direct access blocked.
// - Sequence side copies source words at scan end.
// - Motion side copies refresh words each cycle.
// - Accept addresses 10000..24335, offset minus 10000.
// - Reject ordinary shared range 0..4095.
// - Double-word access uses address and next.
// - Processor selector targets CPU 1..4.
// - Bad power-on configuration raises error 7011.
// - Peer copies read-only, own area writable.
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`include "mcsm_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module mcsm_shared_mem #(
    parameter integer CYCLE_CLKS = `MCSM_CYCLE_CLKS
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        reset_n,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    output reg         irq,
    // Pins
    input  wire        op_cycle_sync,
    input  wire        strap_backplane_ok,
    input  wire        strap_cpu1_seq,
    input  wire [3:0]  strap_present,
    input  wire [1:0]  strap_self,
    output reg         multiprocessor_config_error,
    // Program events
    input  wire        scan_end,
    input  wire        main_cycle,
    // Link transmit
    output reg         tx_valid,
    output reg         tx_last,
    output reg  [15:0] tx_data,
    input  wire        tx_ready,
    // Link receive
    input  wire        rx_valid,
    input  wire [1:0]  rx_src,
    input  wire        rx_last,
    input  wire [15:0] rx_data,
    // Device memory port
    output reg         dev_req,
    output reg         dev_we,
    output reg  [15:0] dev_addr,
    output reg  [15:0] dev_wdata,
    input  wire [15:0] dev_rdata
);
    reg  [15:0] mem [0:`MCSM_MEM_WORDS-1];
    reg  [8:0]  pin_s1_q, pin_s2_q, pin_s3_q;
    reg         op_lvl_q;
    reg  [2:0]  chk_cnt_q;
    reg         cfg_done_q;
    reg  [3:0]  present_q;
    reg  [1:0]  self_q;
    reg         run_en_q, ref_en_q;
    reg  [1:0]  ref_peer_q;
    reg  [15:0] a_q;
    reg  [15:0] ref_src_q, ref_dst_q;
    reg  [15:0] acc_addr_q;
    reg  [1:0]  acc_sel_q, acc_mode_q;
    reg  [3:0]  acc_bit_q;
    reg  [5:0]  status_q, mask_q;
    reg         pend_q, a_wr_q;
    reg  [7:0]  a_off_q;
    reg  [17:0] cyc_cnt_q;
    reg         tx_req_q, tx_busy_q;
    reg  [15:0] tx_ptr_q;
    reg  [3:0]  rx_busy_q;
    reg  [15:0] rx_ptr_q;
    reg  [4:0]  rf_state_q;
    reg         rf_req_q, rf_dir_q;
    reg  [15:0] rf_cnt_q, rf_len_q;
    reg  [15:0] rf_word_q;
    wire [59:0] ref_w;
    wire [63:0] sz_w, base_w, ulen_w, rbase_w;
    wire [3:0]  ref_bad;
    genvar g;

    // Per-processor area layout and refresh size registers.
    generate
        for (g = 0; g < 4; g = g + 1) begin : cpu
            localparam integer OFFI = `MCSM_OFF_REF0 + g * 4;
            localparam [14:0] REF_RST = `MCSM_REF_RST;
            reg [13:0] ref_half_q;
            always @(posedge mclk) begin
                if (!reset_n) begin
                    ref_half_q <= REF_RST[14:1];
                end else if (pend_q && a_wr_q && a_off_q == OFFI[7:0]) begin
                    ref_half_q <= hwdata[14:1];
                end
            end
            assign ref_w[g*15 +: 15] = {ref_half_q, 1'b0};
            assign sz_w[g*16 +: 16] = present_q[g] ?
                {2'b00, a_q[g*4 +: 4], 10'h000} : 16'h0000;
            if (g == 0) begin : first
                assign base_w[15:0] = 16'h0000;
            end else begin : next
                assign base_w[g*16 +: 16] = base_w[(g-1)*16 +: 16] +
                    sz_w[(g-1)*16 +: 16];
            end
            assign ref_bad[g] = {1'b0, ref_w[g*15 +: 15]} > sz_w[g*16 +: 16];
            assign ulen_w[g*16 +: 16] = sz_w[g*16 +: 16] -
                {1'b0, ref_w[g*15 +: 15]};
            assign rbase_w[g*16 +: 16] = base_w[g*16 +: 16] +
                ulen_w[g*16 +: 16];
        end
    endgenerate

    // Configuration and size checks.
    wire [2:0] ncpu = {2'b00, present_q[0]} + {2'b00, present_q[1]} +
                      {2'b00, present_q[2]} + {2'b00, present_q[3]};
    wire [5:0] total_k = {2'b00, sz_w[13:10]} + {2'b00, sz_w[29:26]} +
                         {2'b00, sz_w[45:42]} + {2'b00, sz_w[61:58]};
    wire [5:0] limit_k = (ncpu == 3'h4) ? `MCSM_LIMIT_4CPU :
                         (ncpu == 3'h3) ? `MCSM_LIMIT_3CPU :
                         `MCSM_LIMIT_2CPU;
    wire size_ok = (total_k <= limit_k) && (ref_bad == 4'h0);
    wire cfg_ok  = cfg_done_q && !multiprocessor_config_error;
    wire run     = run_en_q && cfg_ok && size_ok;

    // Area-device address decode.
    wire [15:0] acc_off  = acc_addr_q - `MCSM_AREA_LO;
    wire in_range = (acc_addr_q >= `MCSM_AREA_LO) &&
                    (acc_addr_q <= `MCSM_AREA_HI);
    wire shared_hit = acc_addr_q <= `MCSM_SHARED_TOP;
    wire is_dw = acc_mode_q == `MCSM_MODE_DWORD;
    wire [15:0] sel_ulen = ulen_w[acc_sel_q*16 +: 16];
    wire [15:0] acc_last = acc_off + {15'h0000, is_dw};
    wire acc_ok_rd = in_range && !shared_hit && size_ok && cfg_ok &&
                     present_q[acc_sel_q] && (acc_last < sel_ulen) &&
                     (acc_mode_q != 2'h3);
    wire acc_ok_wr = acc_ok_rd && (acc_sel_q == self_q);
    wire [15:0] acc_idx  = base_w[acc_sel_q*16 +: 16] + acc_off;
    wire [15:0] acc_idx1 = acc_idx + 16'h0001;
    wire [15:0] acc_w0 = mem[acc_idx[13:0]];
    wire [15:0] acc_w1 = mem[acc_idx1[13:0]];
    reg  [31:0] acc_rd;
    reg  [15:0] acc_bitw;
    always @* begin
        acc_bitw = acc_w0;
        acc_bitw[acc_bit_q] = hwdata[0];
        case (acc_mode_q)
            `MCSM_MODE_BIT:   acc_rd = {31'h00000000, acc_w0[acc_bit_q]};
            `MCSM_MODE_DWORD: acc_rd = {acc_w1, acc_w0};
            default:          acc_rd = {16'h0000, acc_w0};
        endcase
    end

    // A data access waits while the addressed copy is being updated.
    wire is_data = a_off_q == `MCSM_OFF_ACCDATA;
    wire own_busy = tx_busy_q || (rf_state_q != `MCSM_RF_IDLE && rf_dir_q);
    wire blocked = is_data && (rx_valid || ((acc_sel_q == self_q) ?
                   own_busy : rx_busy_q[acc_sel_q]));
    wire done = pend_q && !blocked;
    wire acc_wr = done && a_wr_q && is_data;
    wire acc_do_wr = acc_wr && acc_ok_wr;
    wire acc_err = done && is_data && !(a_wr_q ? acc_ok_wr : acc_ok_rd);

    // Receive, refresh and access writes share one memory port.
    wire [15:0] rx_sz = sz_w[rx_src*16 +: 16];
    wire rx_take = rx_valid && run && (rx_src != self_q) &&
                   present_q[rx_src];
    wire rx_wr = rx_take && (rx_ptr_q < rx_sz);
    wire [15:0] rx_idx = base_w[rx_src*16 +: 16] + rx_ptr_q;
    wire [15:0] rf_own = rbase_w[self_q*16 +: 16] + rf_cnt_q;
    wire [15:0] rf_peer = rbase_w[ref_peer_q*16 +: 16] + rf_cnt_q;
    wire rf_put = (rf_state_q == `MCSM_RF_PUT) && !rx_valid;
    wire [15:0] tx_idx = base_w[self_q*16 +: 16] + tx_ptr_q;
    wire [15:0] tx_len = sz_w[self_q*16 +: 16];

    always @(posedge mclk) begin
        if (rx_wr) begin
            mem[rx_idx[13:0]] <= rx_data;
        end else if (rf_put) begin
            mem[rf_own[13:0]] <= rf_word_q;
        end else if (acc_do_wr) begin
            if (acc_mode_q == `MCSM_MODE_BIT) begin
                mem[acc_idx[13:0]] <= acc_bitw;
            end else begin
                mem[acc_idx[13:0]] <= hwdata[15:0];
            end
            if (is_dw) begin
                mem[acc_idx1[13:0]] <= hwdata[31:16];
            end
        end
    end

    // Pin synchronisers and the power-on configuration check.
    wire [8:0] pin_in = {op_cycle_sync, strap_backplane_ok,
                         strap_cpu1_seq, strap_present, strap_self};
    wire op_rise = (pin_s2_q[8] == pin_s3_q[8]) && pin_s3_q[8] && !op_lvl_q;
    always @(posedge mclk) begin
        if (!reset_n) begin
            pin_s1_q <= 9'h000;
            pin_s2_q <= 9'h000;
            pin_s3_q <= 9'h000;
            op_lvl_q <= 1'b0;
            chk_cnt_q <= 3'h0;
            cfg_done_q <= 1'b0;
            present_q <= 4'h0;
            self_q <= 2'h0;
            multiprocessor_config_error <= 1'b0;
        end else begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            if (pin_s2_q[8] == pin_s3_q[8]) begin
                op_lvl_q <= pin_s3_q[8];
            end
            // Straps are taken once the synchronisers have filled.
            if (!cfg_done_q) begin
                if (chk_cnt_q == `MCSM_CHK_WAIT &&
                    pin_s2_q[7:0] == pin_s3_q[7:0]) begin
                    cfg_done_q <= 1'b1;
                    present_q <= pin_s3_q[5:2];
                    self_q <= pin_s3_q[1:0];
                    multiprocessor_config_error <= !(pin_s3_q[7] &&
                        pin_s3_q[6] && pin_s3_q[2] &&
                        pin_s3_q[2 + pin_s3_q[1:0]]);
                end else if (chk_cnt_q != `MCSM_CHK_WAIT) begin
                    chk_cnt_q <= chk_cnt_q + 3'h1;
                end
            end
        end
    end

    // Cycle timer, restarted by the motion operation cycle.
    wire cyc_end = {14'h0000, cyc_cnt_q} == CYCLE_CLKS - 1;
    wire cyc_start = cyc_end || op_rise;
    wire tx_go = (tx_req_q || cyc_start) && run && !tx_busy_q &&
                 (rf_state_q == `MCSM_RF_IDLE);
    reg tx_fin;
    always @(posedge mclk) begin
        tx_fin <= 1'b0;
        if (!reset_n) begin
            cyc_cnt_q <= 18'h00000;
            tx_req_q <= 1'b0;
            tx_busy_q <= 1'b0;
            tx_ptr_q <= 16'h0000;
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
            tx_data <= 16'h0000;
        end else begin
            cyc_cnt_q <= cyc_start ? 18'h00000 : cyc_cnt_q + 18'h00001;
            // A start is held over while the refresh engine owns the area.
            if (tx_go) begin
                tx_req_q <= 1'b0;
                tx_busy_q <= 1'b1;
                tx_ptr_q <= 16'h0000;
            end else if (cyc_start && run) begin
                tx_req_q <= 1'b1;
            end
            if (tx_busy_q && (!tx_valid || tx_ready)) begin
                if (tx_ptr_q < tx_len) begin
                    tx_valid <= 1'b1;
                    tx_data <= mem[tx_idx[13:0]];
                    tx_last <= tx_ptr_q == tx_len - 16'h0001;
                    tx_ptr_q <= tx_ptr_q + 16'h0001;
                end else begin
                    tx_valid <= 1'b0;
                    tx_last <= 1'b0;
                    tx_busy_q <= 1'b0;
                    tx_fin <= 1'b1;
                end
            end
        end
    end

    // Receive framing; readers of a peer copy wait until its last word.
    reg rx_fin;
    always @(posedge mclk) begin
        rx_fin <= 1'b0;
        if (!reset_n) begin
            rx_busy_q <= 4'h0;
            rx_ptr_q <= 16'h0000;
        end else if (rx_take) begin
            if (rx_last) begin
                rx_ptr_q <= 16'h0000;
                rx_busy_q[rx_src] <= 1'b0;
                rx_fin <= 1'b1;
            end else begin
                rx_ptr_q <= rx_ptr_q + 16'h0001;
                rx_busy_q[rx_src] <= 1'b1;
            end
        end
    end

    // Automatic refresh engine.
    wire seq_side = self_q == 2'h0;
    wire rf_trig = ref_en_q && run && (seq_side ? scan_end : main_cycle);
    wire rf_ok = seq_side ? !tx_busy_q : !rx_busy_q[ref_peer_q];
    reg rf_fin;
    always @(posedge mclk) begin
        rf_fin <= 1'b0;
        dev_req <= 1'b0;
        if (!reset_n) begin
            rf_state_q <= `MCSM_RF_IDLE;
            rf_req_q <= 1'b0;
            rf_dir_q <= 1'b0;
            rf_cnt_q <= 16'h0000;
            rf_len_q <= 16'h0000;
            rf_word_q <= 16'h0000;
            dev_we <= 1'b0;
            dev_addr <= 16'h0000;
            dev_wdata <= 16'h0000;
        end else begin
            if (rf_trig) begin
                rf_req_q <= 1'b1;
            end
            case (rf_state_q)
                `MCSM_RF_IDLE: begin
                    if ((rf_req_q || rf_trig) && rf_ok && !tx_req_q) begin
                        rf_req_q <= 1'b0;
                        rf_dir_q <= seq_side;
                        rf_cnt_q <= 16'h0000;
                        rf_len_q <= {1'b0, seq_side ? ref_w[self_q*15 +: 15] :
                                     ref_w[ref_peer_q*15 +: 15]};
                        rf_state_q <= `MCSM_RF_RD;
                    end
                end
                `MCSM_RF_RD: begin
                    if (rf_cnt_q == rf_len_q) begin
                        rf_fin <= 1'b1;
                        rf_state_q <= `MCSM_RF_IDLE;
                    end else if (rf_dir_q) begin
                        dev_req <= 1'b1;
                        dev_we <= 1'b0;
                        dev_addr <= ref_src_q + rf_cnt_q;
                        rf_state_q <= `MCSM_RF_WAIT;
                    end else begin
                        dev_req <= 1'b1;
                        dev_we <= 1'b1;
                        dev_addr <= ref_dst_q + rf_cnt_q;
                        dev_wdata <= mem[rf_peer[13:0]];
                        rf_cnt_q <= rf_cnt_q + 16'h0001;
                    end
                end
                `MCSM_RF_WAIT: rf_state_q <= `MCSM_RF_CAP;
                `MCSM_RF_CAP: begin
                    rf_word_q <= dev_rdata;
                    rf_state_q <= `MCSM_RF_PUT;
                end
                `MCSM_RF_PUT: begin
                    if (rf_put) begin
                        rf_cnt_q <= rf_cnt_q + 16'h0001;
                        rf_state_q <= `MCSM_RF_RD;
                    end
                end
                default: rf_state_q <= `MCSM_RF_IDLE;
            endcase
        end
    end

    // Register read mux.
    reg [31:0] rd_val;
    always @* begin
        case (a_off_q)
            `MCSM_OFF_CTRL:    rd_val = {28'h0000000, ref_peer_q, ref_en_q,
                                         run_en_q};
            `MCSM_OFF_SIZE:    rd_val = {16'h0000, a_q};
            `MCSM_OFF_REF0:    rd_val = {17'h00000, ref_w[14:0]};
            `MCSM_OFF_REF1:    rd_val = {17'h00000, ref_w[29:15]};
            `MCSM_OFF_REF2:    rd_val = {17'h00000, ref_w[44:30]};
            `MCSM_OFF_REF3:    rd_val = {17'h00000, ref_w[59:45]};
            `MCSM_OFF_REFBASE: rd_val = {ref_dst_q, ref_src_q};
            `MCSM_OFF_ACCADDR: rd_val = {8'h00, acc_mode_q, acc_bit_q,
                                         acc_sel_q, acc_addr_q};
            `MCSM_OFF_ACCDATA: rd_val = acc_ok_rd ? acc_rd : 32'h00000000;
            `MCSM_OFF_STATUS:  rd_val = {26'h0000000, status_q};
            `MCSM_OFF_MASK:    rd_val = {26'h0000000, mask_q};
            `MCSM_OFF_INFO:    rd_val = {1'b0, size_ok, own_busy, cfg_done_q,
                                         1'b0, ncpu, self_q, present_q,
                                         multiprocessor_config_error ?
                                         `MCSM_ERR_CODE : 16'h0000};
            default:           rd_val = 32'h00000000;
        endcase
    end

    // AHB-Lite slave: every transfer has at least one wait state.
    wire wr_ok = done && a_wr_q;
    wire [5:0] st_set;
    assign st_set[`MCSM_ST_TXDONE]  = tx_fin;
    assign st_set[`MCSM_ST_RXDONE]  = rx_fin;
    assign st_set[`MCSM_ST_ACCERR]  = acc_err;
    assign st_set[`MCSM_ST_SIZEERR] = run_en_q && cfg_ok && !size_ok;
    assign st_set[`MCSM_ST_REFDONE] = rf_fin;
    assign st_set[`MCSM_ST_CFGERR]  = multiprocessor_config_error;
    wire [5:0] st_clr = (wr_ok && a_off_q == `MCSM_OFF_STATUS) ?
                        hwdata[5:0] : 6'h00;
    always @(posedge mclk) begin
        if (!reset_n) begin
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
            irq <= 1'b0;
            pend_q <= 1'b0;
            a_wr_q <= 1'b0;
            a_off_q <= 8'h00;
            {ref_peer_q, ref_en_q, run_en_q} <= `MCSM_CTRL_RST;
            a_q <= `MCSM_SIZE_RST;
            ref_src_q <= 16'h0000;
            ref_dst_q <= 16'h0000;
            acc_addr_q <= 16'h0000;
            acc_sel_q <= 2'h0;
            acc_bit_q <= 4'h0;
            acc_mode_q <= `MCSM_MODE_WORD;
            status_q <= `MCSM_IRQ_RST;
            mask_q <= `MCSM_IRQ_RST;
        end else begin
            hresp <= 1'b0;
            // New events win over a clear in the same cycle.
            status_q <= (status_q & ~st_clr) | st_set;
            irq <= |(status_q & mask_q);
            if (hsel && htrans[1] && hready) begin
                pend_q <= 1'b1;
                hreadyout <= 1'b0;
                a_wr_q <= hwrite && (hsize == 3'h2);
                a_off_q <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
            end else if (done) begin
                pend_q <= 1'b0;
                hreadyout <= 1'b1;
                hrdata <= a_wr_q ? 32'h00000000 : rd_val;
            end
            if (wr_ok) begin
                case (a_off_q)
                    `MCSM_OFF_CTRL:
                        {ref_peer_q, ref_en_q, run_en_q} <= hwdata[3:0];
                    `MCSM_OFF_SIZE:    a_q <= hwdata[15:0];
                    `MCSM_OFF_REFBASE: begin
                        ref_src_q <= hwdata[15:0];
                        ref_dst_q <= hwdata[31:16];
                    end
                    `MCSM_OFF_ACCADDR: begin
                        acc_addr_q <= hwdata[15:0];
                        acc_sel_q <= hwdata[17:16];
                        acc_bit_q <= hwdata[21:18];
                        acc_mode_q <= hwdata[23:22];
                    end
                    `MCSM_OFF_MASK:    mask_q <= hwdata[5:0];
                    default: ;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/mcsm_shared_mem_asserts.sv ----
// Port assertions for the cyclic shared-memory exchange block.
// Assumes binding onto mcsm_shared_mem; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module mcsm_shared_mem_asserts (
    input wire logic        mclk, reset_n, hsel, hready, hreadyout, hresp,
    input wire logic [1:0]  htrans,
    input wire logic        tx_valid, tx_ready, tx_last, dev_req, dev_we,
    input wire logic [15:0] tx_data,
    input wire logic        multiprocessor_config_error
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_take; hsel && htrans[1] && hready && hreadyout; endsequence
    sequence s_held; tx_valid && $stable(tx_data) && $stable(tx_last);
    endsequence
    property p_take_wait; s_take |=> !hreadyout; endproperty
    property p_okay; hresp == 1'b0; endproperty
    property p_tx_hold; tx_valid && !tx_ready |=> s_held; endproperty
    property p_tx_end; tx_valid && tx_ready && tx_last |=> !tx_valid;
    endproperty
    property p_dev_pulse; dev_req && !dev_we |=> !dev_req; endproperty
    property p_err_sticky; multiprocessor_config_error |=>
        multiprocessor_config_error; endproperty
    property p_err_quiet; multiprocessor_config_error |-> !tx_valid;
    endproperty
    property p_cfg_late; $rose(reset_n) |->
        !multiprocessor_config_error [*5]; endproperty
    a_take_wait: assert property (p_take_wait) else $error("no wait");
    a_okay: assert property (p_okay) else $error("bad hresp");
    a_tx_hold: assert property (p_tx_hold) else $error("tx moved");
    a_tx_end: assert property (p_tx_end) else $error("tx ran on");
    a_dev_pulse: assert property (p_dev_pulse) else $error("dev req");
    a_err_sticky: assert property (p_err_sticky) else $error("err");
    a_err_quiet: assert property (p_err_quiet) else $error("tx err");
    a_cfg_late: assert property (p_cfg_late) else $error("early");
endmodule
bind mcsm_shared_mem mcsm_shared_mem_asserts u_chk (.*);
`default_nettype wire

// ---- verification/mcsm_peer_model.sv ----
// Peer processor on the link: takes send frames, sends a short frame.
// Assumes the block's clock; ready toggles so every word after a frame's first sees a stall.
`timescale 1ns/1ps
`default_nettype none
module mcsm_peer_model #(parameter int CAP = 200) (
    input wire logic        mclk, reset_n, tx_valid, tx_last, send,
    input wire logic [15:0] tx_data,
    output logic            tx_ready, rx_valid, rx_last,
    output logic [1:0]      rx_src,
    output logic [15:0]     rx_data, got_n, got_cap
);
    logic [15:0] k;
    logic [3:0]  rk;
    always @(posedge mclk) begin
        if (!reset_n) begin
            tx_ready <= 1'b0; rx_valid <= 1'b0; rx_last <= 1'b0;
            rx_src <= 2'h1; rx_data <= 16'h0000; k <= 16'h0000; rk <= 4'h0;
        end else begin
            tx_ready <= ~tx_ready;
            if (tx_valid && tx_ready) begin
                k <= tx_last ? 16'h0000 : k + 16'h0001;
                if (k == CAP) got_cap <= tx_data;
                if (tx_last) got_n <= k + 16'h0001;
            end
            // Peer is CPU2.
            if (rk != 4'h0) begin
                rx_valid <= 1'b1;
                rx_data <= 16'hC000 + {12'h000, rk} - 16'h0001;
                rx_last <= (rk == 4'h8);
                rk <= (rk == 4'h8) ? 4'h0 : rk + 4'h1;
            end else begin
                // Idle line drops valid and inverts the data word every cycle.
                rx_valid <= 1'b0; rx_last <= 1'b0; rx_data <= ~rx_data;
                if (send) rk <= 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/mcsm_shared_mem_test.sv ----
// Self-checking bench of the shared-memory exchange block.
// Assumes the peer model, the checker bind and a behavioural device memory.
`include "mcsm_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module mcsm_shared_mem_test;
    localparam int CYC = 4000;
    logic mclk = 0, reset_n = 0, hsel = 1, hwrite = 0, scan_end = 0;
    logic main_cycle = 0, sync = 0, seq = 0, send = 0, irq, cerr;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0] htrans = 0, rx_src;
    logic [15:0] dev_rdata = 0, dev_addr, tx_data, rx_data, got_n, got_cap;
    logic hreadyout, tx_valid, tx_last, tx_ready, rx_valid, rx_last;
    int failures = 0, compares = 0, cyc = 0;
    mcsm_shared_mem #(.CYCLE_CLKS(CYC)) uut (.*, .hsize(3'h2),
        .hready(hreadyout), .hresp(), .op_cycle_sync(sync),
        .strap_backplane_ok(1'b1), .strap_cpu1_seq(seq),
        .strap_present(4'h3), .strap_self(2'h0),
        .multiprocessor_config_error(cerr), .dev_req(), .dev_we(),
        .dev_wdata());
    mcsm_peer_model peer (.*);
    initial forever #2 mclk = ~mclk;
    always @(posedge mclk) dev_rdata <= ~dev_addr;
    always @(posedge mclk) if (++cyc == 40000) begin
        failures++;
        tally_and_finish;
    end
    task chk(string n, logic [31:0] e, s);
        compares++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task ahb(logic w, logic [31:0] a, d);
        htrans <= 2'h2; hwrite <= w; haddr <= a;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    function automatic logic [31:0] acc(logic [1:0] m, logic [3:0] b,
        logic [1:0] s, logic [15:0] a);
        return {8'h00, m, b, s, a};
    endfunction
    task rst;
        reset_n <= 1'b0;
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (20) @(posedge mclk);
    endtask
    task t_cfg;
        rst;
        chk("cfg_err", 1, cerr);
        ahb(0, `MCSM_OFF_INFO, 0); chk("code", `MCSM_ERR_CODE, r[15:0]);
        seq <= 1'b1;
        rst;
        chk("cfg_ok", 0, cerr);
        $display("test cfg done");
    endtask
    task t_access;
        ahb(1, `MCSM_OFF_SIZE, 32'h11); ahb(1, `MCSM_OFF_REF0, 2);
        ahb(1, `MCSM_OFF_ACCADDR, acc(2, 0, 0, 16'h27D8));
        ahb(1, `MCSM_OFF_ACCDATA, 32'h12345678);
        ahb(1, `MCSM_OFF_ACCADDR, acc(0, 0, 0, 16'h27D9));
        ahb(0, `MCSM_OFF_ACCDATA, 0); chk("dword_hi", 16'h1234, r[15:0]);
        ahb(1, `MCSM_OFF_ACCADDR, acc(1, 14, 0, 16'h27D8));
        ahb(0, `MCSM_OFF_ACCDATA, 0); chk("bit_e", 1, r[0]);
        for (int i = 0; i < 3; i++) begin
            ahb(1, `MCSM_OFF_ACCADDR, acc(0, 0, i / 2,
                i == 0 ? 16'h0FFF : i == 1 ? 16'h5F10 : 16'h2710));
            ahb(i / 2, `MCSM_OFF_ACCDATA, 5);
            ahb(0, `MCSM_OFF_STATUS, 0); chk("reject", 1, r[2]);
            ahb(1, `MCSM_OFF_STATUS, 4);
        end
        ahb(0, 32'h100, 0); chk("unmapped", 0, r);
        $display("test access done");
    endtask
    task t_tx;
        int n = 0;
        ahb(1, `MCSM_OFF_MASK, 1); ahb(1, `MCSM_OFF_CTRL, 3);
        scan_end <= 1'b1; @(posedge mclk); scan_end <= 1'b0;
        do @(posedge mclk); while (tx_valid !== 1'b1);
        do begin @(posedge mclk); n++; end while (tx_valid !== 1'b0);
        do begin @(posedge mclk); n++; end while (tx_valid !== 1'b1);
        chk("period", CYC, n);
        do @(posedge mclk); while (tx_valid !== 1'b0);
        repeat (4) @(posedge mclk);
        chk("words", 1024, got_n);
        chk("word200", 16'h5678, got_cap);
        ahb(0, `MCSM_OFF_STATUS, 0); chk("refresh", 1, r[4]);
        chk("irq_on", 1, irq);
        ahb(1, `MCSM_OFF_MASK, 0); repeat (2) @(posedge mclk);
        chk("irq_mask", 0, irq);
        ahb(1, `MCSM_OFF_MASK, 1); ahb(1, `MCSM_OFF_STATUS, 32'h3F);
        repeat (2) @(posedge mclk);
        chk("irq_clr", 0, irq);
        $display("test tx done");
    endtask
    task t_rx;
        send <= 1'b1; @(posedge mclk); send <= 1'b0;
        repeat (14) @(posedge mclk);
        ahb(0, `MCSM_OFF_STATUS, 0); chk("rx_done", 1, r[1]);
        ahb(1, `MCSM_OFF_ACCADDR, acc(0, 0, 1, 16'h2713));
        ahb(0, `MCSM_OFF_ACCDATA, 0); chk("peer3", 16'hC003, r[15:0]);
        $display("test rx done");
    endtask
    task tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        t_cfg;
        t_access;
        t_tx;
        t_rx;
        tally_and_finish;
    end
endmodule
`default_nettype wire
